// ### src/dsom_pkg.sv
// Package for the drive status output and overload monitor
package dsom_pkg;

  // APB register offsets
  localparam logic [7:0] ADDR_FREQ = 8'h00;
  localparam logic [7:0] ADDR_SEL = 8'h04;
  localparam logic [7:0] ADDR_THERM = 8'h08;
  localparam logic [7:0] ADDR_OVL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CURRENT = 8'h14;

  // Frequencies in 0.01 Hz
  localparam logic [15:0] FREQ_MAX_RANGE = 16'h9c40;
  localparam logic [15:0] LEVEL_RST = 16'h0bb8;
  localparam logic [15:0] BAND_RST = 16'h03e8;
  localparam logic [15:0] FMAX_RST = 16'h1770;

  localparam logic [4:0] COLL_SEL_RST = 5'h0c;
  localparam logic [4:0] RELAY_SEL_RST = 5'h11;
  localparam logic [2:0] MASK_RST = 3'h2;
  localparam logic [1:0] KPAD_RST = 2'h0;

  localparam logic [7:0] ONE_MIN_RST = 8'h96;
  localparam logic [7:0] CONT_RST = 8'h64;
  localparam logic [7:0] WARN_LVL_RST = 8'h96;
  localparam logic [7:0] WARN_TIME_RST = 8'h0a;
  localparam logic [7:0] TRIP_LVL_RST = 8'hb4;
  localparam logic [7:0] TRIP_TIME_RST = 8'h3c;

  // Output select codes
  localparam logic [4:0] SEL_WINDOW = 5'h02;
  localparam logic [4:0] SEL_HYST = 5'h03;
  localparam logic [4:0] SEL_HYST_INV = 5'h04;
  localparam logic [4:0] SEL_OVL = 5'h05;
  localparam logic [4:0] SEL_OVV = 5'h08;
  localparam logic [4:0] SEL_LOWV = 5'h09;
  localparam logic [4:0] SEL_HEAT = 5'h0a;
  localparam logic [4:0] SEL_CMDLOSS = 5'h0b;
  localparam logic [4:0] SEL_RUN = 5'h0c;
  localparam logic [4:0] SEL_STOP = 5'h0d;
  localparam logic [4:0] SEL_CONST = 5'h0e;
  localparam logic [4:0] SEL_WAIT = 5'h10;
  localparam logic [4:0] SEL_FAULT = 5'h11;
  localparam logic [4:0] SEL_FAN = 5'h12;
  localparam logic [4:0] SEL_BRAKE = 5'h13;

  // DC link trip limits in volts
  localparam logic [9:0] OVV_200 = 10'h190;
  localparam logic [9:0] OVV_400 = 10'h334;
  localparam logic [9:0] LOWV_200 = 10'h0b4;
  localparam logic [9:0] LOWV_400 = 10'h168;

  // Timing: 25 MHz pclk
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_S = 1000 / TICK_MS;
  localparam logic [15:0] KPAD_ERR_TICKS_RST = 16'h0064;
  // Thermal accumulator full scale: one-minute level held 60 s
  localparam logic [31:0] THERM_FULL = 32'h0000_1770;
  // Low-speed derate point for shaft fan, 0.01 Hz
  localparam logic [15:0] LOWSPD_FREQ = 16'h0bb8;

  typedef struct packed {
    logic run_cmd;
    logic output_active;
    logic accel;
    logic decel;
    logic analog_lost;
    logic link_lost;
    logic heatsink_overheat;
    logic fan_trip;
    logic brake_ctrl;
    logic other_trip;
    logic restart_pending;
    logic keypad_comm_err;
    logic class_400v;
  } dsom_status_type;

endpackage

// ### src/dsom_persist.sv
// Persistence timer: flags a condition held for a number of ticks
`timescale 1ns/1ps
`default_nettype none
module dsom_persist (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Condition and timing
  input wire logic tick,
  input wire logic cond,
  input wire logic [15:0] limit,
  // Result
  output logic held
);

  typedef struct packed {
    logic [15:0] cnt;
    logic held;
  } dsom_persist_state_type;

  dsom_persist_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!cond) begin
      // Drops at once when the condition goes away
      s_d.cnt = 16'h0000;
      s_d.held = 1'b0;
    end else if (s_q.cnt >= limit) begin
      s_d.held = 1'b1;
    end else if (tick) begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign held = s_q.held;

endmodule
`default_nettype wire

// ### src/dsom_top.sv
// Status output selector and motor overload monitor with APB registers
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dsom_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive measurements, same clock domain
  input wire logic [15:0] run_freq,
  input wire logic [9:0] dc_link_volts,
  input wire logic [7:0] motor_current_pct,
  input wire dsom_pkg::dsom_status_type drive_status,
  // Outputs
  output logic open_collector_output,
  output logic relay_contacts,
  output logic keypad_error,
  output logic output_shutoff
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [15:0] level;
    logic [15:0] band;
    logic [15:0] fmax;
    logic [4:0] coll_sel;
    logic [4:0] relay_sel;
    logic [2:0] mask;
    logic [1:0] kpad;
    logic therm_en;
    logic cooling;
    logic [7:0] one_min;
    logic [7:0] cont;
    logic [7:0] warn_lvl;
    logic [7:0] warn_time;
    logic trip_en;
    logic [7:0] trip_lvl;
    logic [7:0] trip_time;
    logic [31:0] tick_cnt;
    logic [31:0] heat;
    logic therm_trip;
    logic ovl_trip;
    logic ovv;
    logic lowv;
    logic oc_out;
    logic relay_out;
    logic [31:0] rdata;
  } dsom_state_type;

  dsom_state_type s_q, s_d;

  logic tick;
  logic kpad_err;
  logic warn_held;
  logic trip_held;
  logic [15:0] warn_ticks;
  logic [15:0] trip_ticks;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = (paddr == dsom_pkg::ADDR_FREQ) || (paddr == dsom_pkg::ADDR_SEL) ||
                   (paddr == dsom_pkg::ADDR_THERM) || (paddr == dsom_pkg::ADDR_OVL) ||
                   (paddr == dsom_pkg::ADDR_STATUS) || (paddr == dsom_pkg::ADDR_CURRENT);
  assign pslverr = psel && penable && !addr_ok;
  assign tick = (s_q.tick_cnt == 32'(dsom_pkg::TICK_CYCLES - 1));

  assign warn_ticks = 16'(s_q.warn_time * dsom_pkg::TICKS_PER_S);
  assign trip_ticks = 16'(s_q.trip_time * dsom_pkg::TICKS_PER_S);

  ////////////////////////////////////////////////////////////////////////////
  // Persistence timers
  dsom_persist u_kpad (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .cond(drive_status.keypad_comm_err),
    .limit(dsom_pkg::KPAD_ERR_TICKS_RST),
    .held(kpad_err)
  );

  dsom_persist u_warn (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .cond(motor_current_pct > s_q.warn_lvl),
    .limit(warn_ticks),
    .held(warn_held)
  );

  dsom_persist u_trip (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .cond(s_q.trip_en && (motor_current_pct > s_q.trip_lvl)),
    .limit(trip_ticks),
    .held(trip_held)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output source per selection code
  function automatic logic pick(input logic [4:0] sel, input logic [15:0] f, input logic [15:0] lvl,
                                input logic [15:0] half, input dsom_pkg::dsom_status_type st,
                                input logic ovv, input logic lowv, input logic [2:0] mask,
                                input logic warn);
    logic [16:0] diff;
    logic hyst;
    diff = (f >= lvl) ? {1'b0, f - lvl} : {1'b0, lvl - f};
    if (st.decel) begin
      hyst = ({1'b0, f} + {1'b0, half}) > {1'b0, lvl};
    end else begin
      hyst = f >= lvl;
    end
    unique case (sel)
      dsom_pkg::SEL_WINDOW: pick = diff <= {1'b0, half};
      dsom_pkg::SEL_HYST: pick = hyst;
      dsom_pkg::SEL_HYST_INV: pick = !hyst;
      dsom_pkg::SEL_OVL: pick = warn;
      dsom_pkg::SEL_OVV: pick = ovv;
      dsom_pkg::SEL_LOWV: pick = lowv;
      dsom_pkg::SEL_HEAT: pick = st.heatsink_overheat;
      dsom_pkg::SEL_CMDLOSS: pick = st.analog_lost && st.link_lost;
      dsom_pkg::SEL_RUN: pick = st.run_cmd && st.output_active;
      dsom_pkg::SEL_STOP: pick = !st.run_cmd && !st.output_active;
      dsom_pkg::SEL_CONST: pick = st.output_active && !st.accel && !st.decel;
      dsom_pkg::SEL_WAIT: pick = !st.run_cmd && !st.other_trip && !lowv;
      dsom_pkg::SEL_FAULT: pick = (mask[0] && lowv) || (mask[1] && (st.other_trip || ovv)) ||
                                  (mask[2] && st.restart_pending);
      dsom_pkg::SEL_FAN: pick = st.fan_trip;
      dsom_pkg::SEL_BRAKE: pick = st.brake_ctrl;
      default: pick = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [15:0] wl;
    logic [7:0] wa;
    logic [7:0] wb;
    logic [15:0] half;
    logic [31:0] over;
    logic [31:0] cool;
    logic [31:0] rd;
    wl = pwdata[15:0];
    wa = pwdata[7:0];
    wb = pwdata[15:8];
    half = {1'b0, s_q.band[15:1]};
    over = 32'h0;
    cool = 32'h0;
    rd = 32'h0;
    s_d = s_q;

    s_d.tick_cnt = tick ? 32'h0 : s_q.tick_cnt + 32'h1;

    // Register writes take effect in the access phase
    if (wr_en) begin
      unique case (paddr)
        dsom_pkg::ADDR_FREQ: begin
          s_d.fmax = (wl > dsom_pkg::FREQ_MAX_RANGE) ? dsom_pkg::FREQ_MAX_RANGE : wl;
        end
        dsom_pkg::ADDR_SEL: begin
          s_d.coll_sel = pwdata[4:0];
          s_d.relay_sel = pwdata[12:8];
          s_d.mask = pwdata[18:16];
          s_d.kpad = pwdata[25:24];
        end
        dsom_pkg::ADDR_THERM: begin
          s_d.therm_en = pwdata[16];
          s_d.cooling = pwdata[17];
          s_d.one_min = (wa < 8'h32) ? 8'h32 : ((wa > 8'hc8) ? 8'hc8 : wa);
          s_d.cont = (wb < 8'h32) ? 8'h32 : ((wb > 8'h96) ? 8'h96 : wb);
        end
        dsom_pkg::ADDR_OVL: begin
          s_d.warn_lvl = (wa < 8'h1e) ? 8'h1e : ((wa > 8'h96) ? 8'h96 : wa);
          s_d.warn_time = (pwdata[15:8] > 8'h1e) ? 8'h1e : pwdata[15:8];
          s_d.trip_lvl = (pwdata[23:16] < 8'h1e) ? 8'h1e :
                         ((pwdata[23:16] > 8'hc8) ? 8'hc8 : pwdata[23:16]);
          s_d.trip_time = (pwdata[30:24] > 7'h3c) ? 8'h3c : {1'b0, pwdata[30:24]};
          s_d.trip_en = pwdata[31];
        end
        // Status is read-only, bandwidth below, anything else unmapped and ignored
        default: begin
        end
      endcase
    end
    // Level takes the high half of the frequency word, bandwidth the low half of the current word
    if (wr_en && paddr == dsom_pkg::ADDR_FREQ) begin
      s_d.level = (pwdata[31:16] > dsom_pkg::FREQ_MAX_RANGE) ? dsom_pkg::FREQ_MAX_RANGE :
                  pwdata[31:16];
    end
    if (wr_en && paddr == dsom_pkg::ADDR_CURRENT) begin
      s_d.band = (wl > dsom_pkg::FREQ_MAX_RANGE) ? dsom_pkg::FREQ_MAX_RANGE : wl;
    end
    // Never above max frequency
    if (s_d.level > s_d.fmax) s_d.level = s_d.fmax;
    if (s_d.band > s_d.fmax) s_d.band = s_d.fmax;
    // One-minute level never below continuous level
    if (s_d.one_min < s_d.cont) s_d.one_min = s_d.cont;

    // DC link trips latch until reset
    if (dc_link_volts > (drive_status.class_400v ? dsom_pkg::OVV_400 : dsom_pkg::OVV_200)) begin
      s_d.ovv = 1'b1;
    end
    if (dc_link_volts < (drive_status.class_400v ? dsom_pkg::LOWV_400 : dsom_pkg::LOWV_200)) begin
      s_d.lowv = 1'b1;
    end

    // Inverse-time model: heat grows with excess over continuous level
    if (s_q.therm_en && tick) begin
      cool = {24'h0, s_q.cont};
      // Shaft fan cools less at low speed
      if (!s_q.cooling && run_freq < dsom_pkg::LOWSPD_FREQ) begin
        cool = {25'h0, s_q.cont[7:1]};
      end
      if ({24'h0, motor_current_pct} > cool) begin
        over = {24'h0, motor_current_pct} - cool;
        s_d.heat = s_q.heat + over;
      end else begin
        s_d.heat = (s_q.heat > 32'h1) ? s_q.heat - 32'h2 : 32'h0;
      end
      // Full scale is one-minute excess held for 60 s of ticks
      // Equal levels give a zero threshold: an empty model must not trip
      if (s_d.heat != 32'h0 &&
          s_d.heat >= 32'({24'h0, s_q.one_min - s_q.cont} * dsom_pkg::THERM_FULL)) begin
        s_d.therm_trip = 1'b1;
      end
    end
    if (trip_held) s_d.ovl_trip = 1'b1;

    s_d.oc_out = pick(s_q.coll_sel, run_freq, s_q.level, half, drive_status, s_q.ovv, s_q.lowv,
                      s_q.mask, warn_held) || (s_q.kpad[0] && kpad_err);
    s_d.relay_out = pick(s_q.relay_sel, run_freq, s_q.level, half, drive_status, s_q.ovv,
                         s_q.lowv, s_q.mask, warn_held) || (s_q.kpad[1] && kpad_err);

    // Read data captured in setup cycle
    if (rd_en) begin
      unique case (paddr)
        dsom_pkg::ADDR_FREQ: rd = {s_q.level, s_q.fmax};
        dsom_pkg::ADDR_SEL: rd = {6'h0, s_q.kpad, 5'h0, s_q.mask, 3'h0, s_q.relay_sel, 3'h0,
                                  s_q.coll_sel};
        dsom_pkg::ADDR_THERM: rd = {14'h0, s_q.cooling, s_q.therm_en, s_q.cont, s_q.one_min};
        dsom_pkg::ADDR_OVL: rd = {s_q.trip_en, s_q.trip_time[6:0], s_q.trip_lvl, s_q.warn_time,
                                  s_q.warn_lvl};
        dsom_pkg::ADDR_STATUS: rd = {24'h0, kpad_err, warn_held, s_q.ovl_trip, s_q.therm_trip,
                                     s_q.lowv, s_q.ovv, s_q.relay_out, s_q.oc_out};
        dsom_pkg::ADDR_CURRENT: rd = {16'h0, s_q.band};
        default: rd = 32'h0;
      endcase
      s_d.rdata = rd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.level <= dsom_pkg::LEVEL_RST;
      s_q.band <= dsom_pkg::BAND_RST;
      s_q.fmax <= dsom_pkg::FMAX_RST;
      s_q.coll_sel <= dsom_pkg::COLL_SEL_RST;
      s_q.relay_sel <= dsom_pkg::RELAY_SEL_RST;
      s_q.mask <= dsom_pkg::MASK_RST;
      s_q.kpad <= dsom_pkg::KPAD_RST;
      s_q.one_min <= dsom_pkg::ONE_MIN_RST;
      s_q.cont <= dsom_pkg::CONT_RST;
      s_q.warn_lvl <= dsom_pkg::WARN_LVL_RST;
      s_q.warn_time <= dsom_pkg::WARN_TIME_RST;
      s_q.trip_en <= 1'b1;
      s_q.trip_lvl <= dsom_pkg::TRIP_LVL_RST;
      s_q.trip_time <= dsom_pkg::TRIP_TIME_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign open_collector_output = s_q.oc_out;
  assign relay_contacts = s_q.relay_out;
  assign keypad_error = kpad_err;
  assign output_shutoff = s_q.therm_trip || s_q.ovl_trip;

endmodule
`default_nettype wire

// ### verification/dsom_top_assertions.sv
// Concurrent checks on the status outputs of the monitor
`timescale 1ns/1ps
`default_nettype none
module dsom_top_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Drive side
  input wire logic [9:0] dc_link_volts,
  input wire logic [7:0] motor_current_pct,
  input wire dsom_pkg::dsom_status_type drive_status,
  input wire logic open_collector_output,
  input wire logic relay_contacts,
  input wire logic output_shutoff
);
  ////////////////////////////////////////////////////////////////
  // Shadow of the selection and warning level, taken off the bus
  logic [31:0] sel_q;
  logic [7:0] wlvl_q;
  logic wr;
  logic [4:0] oc_sel;
  logic [4:0] rl_sel;
  assign wr = psel && penable && pwrite;
  assign oc_sel = sel_q[4:0];
  assign rl_sel = sel_q[12:8];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= {6'h00, dsom_pkg::KPAD_RST, 5'h00, dsom_pkg::MASK_RST, 3'h0, dsom_pkg::RELAY_SEL_RST, 3'h0,
                dsom_pkg::COLL_SEL_RST};
      wlvl_q <= dsom_pkg::WARN_LVL_RST;
    end else begin
      sel_q <= (wr && paddr == dsom_pkg::ADDR_SEL) ? pwdata : sel_q;
      // Warning level limited to 30..150 percent
      if (wr && paddr == dsom_pkg::ADDR_OVL) begin
        wlvl_q <= (pwdata[7:0] < 8'h1e) ? 8'h1e : ((pwdata[7:0] > 8'h96) ? 8'h96 : pwdata[7:0]);
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_run;
    oc_sel == dsom_pkg::SEL_RUN && drive_status.run_cmd && drive_status.output_active |=> open_collector_output;
  endproperty
  a_run: assert property (p_run) else $error("run output missing");
  property p_heat;
    rl_sel == dsom_pkg::SEL_HEAT && !sel_q[25] |=> relay_contacts == $past(drive_status.heatsink_overheat);
  endproperty
  a_heat: assert property (p_heat) else $error("overheat relay wrong");
  property p_const;
    oc_sel == dsom_pkg::SEL_CONST && !sel_q[24] && (drive_status.accel || drive_status.decel)
      |=> !open_collector_output;
  endproperty
  a_const: assert property (p_const) else $error("constant speed while ramping");
  property p_loss;
    oc_sel == dsom_pkg::SEL_CMDLOSS && !sel_q[24]
      |=> open_collector_output == $past(drive_status.analog_lost && drive_status.link_lost);
  endproperty
  a_loss: assert property (p_loss) else $error("command loss output wrong");
  property p_warn;
    // Timer and pin each lag a cycle, so the level must be low two samples running
    oc_sel == dsom_pkg::SEL_OVL && !sel_q[24] && motor_current_pct < wlvl_q &&
      $past(motor_current_pct < wlvl_q) |=> !open_collector_output;
  endproperty
  a_warn: assert property (p_warn) else $error("warning held below level");
  property p_wait;
    oc_sel == dsom_pkg::SEL_WAIT && !sel_q[24] && drive_status.run_cmd |=> !open_collector_output;
  endproperty
  a_wait: assert property (p_wait) else $error("waiting output with run");
  property p_ovv;
    rl_sel == dsom_pkg::SEL_OVV && !drive_status.class_400v && dc_link_volts > 10'h190 |-> ##[1:3] relay_contacts;
  endproperty
  a_ovv: assert property (p_ovv) else $error("over-voltage relay missing");
  property p_lowv;
    oc_sel == dsom_pkg::SEL_LOWV && !drive_status.class_400v && dc_link_volts < 10'h0b4
      |-> ##[1:3] open_collector_output;
  endproperty
  a_lowv: assert property (p_lowv) else $error("low-voltage output missing");
  property p_shut;
    output_shutoff |=> output_shutoff;
  endproperty
  a_shut: assert property (p_shut) else $error("shutoff released");
endmodule
bind dsom_top dsom_top_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .dc_link_volts(dc_link_volts),
  .motor_current_pct(motor_current_pct), .drive_status(drive_status),
  .open_collector_output(open_collector_output), .relay_contacts(relay_contacts), .output_shutoff(output_shutoff));
`default_nettype wire

// ### verification/dsom_seq_model.sv
// External sequence: gives the run command, drops it on relay fault
`timescale 1ns/1ps
`default_nettype none
module dsom_seq_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request and feedback
  input wire logic run_req,
  input wire logic stop_on_relay,
  input wire logic relay_contacts,
  // Command to the drive
  output logic run_cmd
);
  // Registered like a real PLC scan, so the drive sees it a cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cmd <= 1'b0;
    end else begin
      run_cmd <= run_req && !(stop_on_relay && relay_contacts);
    end
  end
endmodule
`default_nettype wire

// ### verification/dsom_top_test.sv
// Self-checking bench for the status output and overload monitor
`timescale 1ns/1ps
`default_nettype none
module dsom_top_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] run_freq = 16'h0bb8;
  logic [9:0] dc_link_volts = 10'h12c;
  logic [7:0] motor_current_pct = 8'h00;
  dsom_pkg::dsom_status_type st = '0;
  dsom_pkg::dsom_status_type ds;
  dsom_pkg::dsom_status_type tmp;
  logic run_req = 1'b0;
  logic stop_on_relay = 1'b0;
  logic run_cmd, oc, relay, kerr, shut, err, ex;
  logic [31:0] rd;
  logic [4:0] code;
  int err_count = 0;
  int cmp_count = 0;
  logic [4:0] codes [15] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e,
                             5'h10, 5'h11, 5'h12, 5'h13};
  always #20 pclk = ~pclk;
  always_comb begin
    ds = st;
    ds.run_cmd = run_cmd;
  end
  dsom_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_freq(run_freq),
    .dc_link_volts(dc_link_volts), .motor_current_pct(motor_current_pct), .drive_status(ds),
    .open_collector_output(oc), .relay_contacts(relay), .keypad_error(kerr), .output_shutoff(shut));
  dsom_seq_model u_seq (.pclk(pclk), .presetn(presetn), .run_req(run_req), .stop_on_relay(stop_on_relay),
    .relay_contacts(relay), .run_cmd(run_cmd));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Expected output for one select code, defaults for level and bandwidth
  function automatic logic expect_out(input logic [4:0] c, input dsom_pkg::dsom_status_type s,
                                      input logic [15:0] f, input logic [7:0] cur);
    logic [15:0] lo;
    logic hy;
    lo = dsom_pkg::LEVEL_RST - (dsom_pkg::BAND_RST >> 1);
    hy = s.decel ? (f > lo) : (f >= dsom_pkg::LEVEL_RST);
    case (c)
      5'h02: return f >= lo && f <= dsom_pkg::LEVEL_RST + (dsom_pkg::BAND_RST >> 1);
      5'h03: return hy;
      5'h04: return !hy;
      5'h05: return cur > 8'h64;
      5'h0a: return s.heatsink_overheat;
      5'h0b: return s.analog_lost && s.link_lost;
      5'h0c: return s.run_cmd && s.output_active;
      5'h0d: return !s.run_cmd && !s.output_active;
      5'h0e: return !s.accel && !s.decel;
      5'h10: return !s.run_cmd && !s.other_trip;
      5'h11: return s.other_trip;
      5'h12: return s.fan_trip;
      5'h13: return s.brake_ctrl;
      default: return 1'b0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    finish_test();
  end
  initial begin
    void'($urandom(32'he3a6));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, dsom_pkg::ADDR_FREQ, 32'h0);
    chk("freq reg", rd, {dsom_pkg::LEVEL_RST, dsom_pkg::FMAX_RST});
    apb(1'b0, dsom_pkg::ADDR_SEL, 32'h0);
    chk("sel reg", rd, {6'h00, dsom_pkg::KPAD_RST, 5'h00, dsom_pkg::MASK_RST, 3'h0, dsom_pkg::RELAY_SEL_RST, 3'h0,
        dsom_pkg::COLL_SEL_RST});
    apb(1'b0, dsom_pkg::ADDR_THERM, 32'h0);
    chk("therm reg", rd, {16'h0000, dsom_pkg::CONT_RST, dsom_pkg::ONE_MIN_RST});
    apb(1'b0, dsom_pkg::ADDR_OVL, 32'h0);
    chk("ovl reg", rd, {1'b1, dsom_pkg::TRIP_TIME_RST[6:0], dsom_pkg::TRIP_LVL_RST, dsom_pkg::WARN_TIME_RST,
        dsom_pkg::WARN_LVL_RST});
    apb(1'b0, dsom_pkg::ADDR_CURRENT, 32'h0);
    chk("band reg", rd, {16'h0000, dsom_pkg::BAND_RST});
    apb(1'b1, 8'h20, 32'hffff_ffff);
    chk("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped data", rd, 32'h0);
    // Zero warning time keeps the warning path inside the run
    apb(1'b1, dsom_pkg::ADDR_OVL, {1'b1, 7'h3c, 8'hb4, 8'h00, 8'h64});
    for (int i = 0; i < 60; i++) begin
      code = codes[$urandom % 15];
      apb(1'b1, dsom_pkg::ADDR_SEL, {16'h0002, 3'h0, code, 3'h0, code});
      tmp = dsom_pkg::dsom_status_type'(13'($urandom) & 13'h1ffc);
      tmp.output_active = tmp.output_active || code == dsom_pkg::SEL_CONST;
      st <= tmp;
      run_req <= tmp.run_cmd;
      run_freq <= i < 3 ? 16'h09c4 + 16'(i) : 16'h07d0 + 16'($urandom % 2001);
      dc_link_volts <= 10'h0b4 + 10'($urandom % 221);
      motor_current_pct <= 8'($urandom % 180);
      repeat (3) @(posedge pclk);
      ex = expect_out(code, ds, run_freq, motor_current_pct);
      chk("collector", {31'h0, oc}, {31'h0, ex});
      chk("relay", {31'h0, relay}, {31'h0, ex});
    end
    apb(1'b1, dsom_pkg::ADDR_SEL, {16'h0002, 3'h0, dsom_pkg::SEL_OVV, 3'h0, dsom_pkg::SEL_LOWV});
    st <= '0;
    run_req <= 1'b1;
    stop_on_relay <= 1'b1;
    dc_link_volts <= 10'h191;
    repeat (4) @(posedge pclk);
    dc_link_volts <= 10'h12c;
    repeat (4) @(posedge pclk);
    chk("ovv latch", {31'h0, relay}, 32'h1);
    chk("seq stop", {31'h0, run_cmd}, 32'h0);
    dc_link_volts <= 10'h0b3;
    repeat (4) @(posedge pclk);
    chk("lowv", {31'h0, oc}, 32'h1);
    apb(1'b1, dsom_pkg::ADDR_OVL, {1'b0, 7'h00, 8'h64, 8'h00, 8'h64});
    motor_current_pct <= 8'hc8;
    repeat (4) @(posedge pclk);
    chk("trip off", {31'h0, shut}, 32'h0);
    apb(1'b1, dsom_pkg::ADDR_OVL, {1'b1, 7'h00, 8'h64, 8'h00, 8'h64});
    for (int n = 0; n < 20 && shut !== 1'b1; n++) @(posedge pclk);
    motor_current_pct <= 8'h00;
    repeat (3) @(posedge pclk);
    chk("trip held", {31'h0, shut}, 32'h1);
    chk("keypad idle", {31'h0, kerr}, 32'h0);
    apb(1'b0, dsom_pkg::ADDR_STATUS, 32'h0);
    chk("status reg", rd, 32'h0000_002f);
    apb(1'b1, dsom_pkg::ADDR_THERM, 32'h0000_9632);
    apb(1'b0, dsom_pkg::ADDR_THERM, 32'h0);
    chk("one-minute floor", rd, 32'h0000_9696);
    apb(1'b1, dsom_pkg::ADDR_FREQ, {16'hffff, dsom_pkg::FMAX_RST});
    apb(1'b0, dsom_pkg::ADDR_FREQ, 32'h0);
    chk("level clamp", rd, {dsom_pkg::FMAX_RST, dsom_pkg::FMAX_RST});
    finish_test();
  end
endmodule
`default_nettype wire
